/* cce_pkg.sv */
// constants, register map and types shared by the crc engine
package cce_pkg;

  // ***************************************************************
  // register byte offsets on the ahb-lite slave
  // ***************************************************************
  localparam logic [7:0]  CONTROL_OFS       = 8'h00;  // crc_control
  localparam logic [7:0]  BYTE_INPUT_OFS    = 8'h04;  // crc_byte_input
  localparam logic [7:0]  RESULT_PORT_OFS   = 8'h08;  // result_byte_port
  localparam logic [7:0]  AUTO_CONTROL_OFS  = 8'h0C;  // flash_auto_control
  localparam logic [7:0]  SECTOR_COUNT_OFS  = 8'h10;  // flash_sector_count
  localparam logic [7:0]  BIT_REVERSE_OFS   = 8'h14;  // bit mirror register

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int          CTL_WIDTH_BIT     = 4;      // poly_width_select
  localparam int          CTL_INIT_BIT      = 3;      // result_init_strobe
  localparam int          CTL_PRESET_BIT    = 2;      // preset_value_select
  localparam int          CTL_PTR_LSB       = 0;      // result_byte_pointer
  localparam int          AUTO_EN_BIT       = 7;      // flash_auto_enable
  localparam int          AUTO_PAGE_W       = 6;      // start page field width

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [31:0] RESULT_RESET      = 32'h00000000;
  localparam logic [7:0]  BYTE_RESET        = 8'h00;
  localparam logic [1:0]  PTR_RESET         = 2'h0;

  // ***************************************************************
  // polynomials, presets, sector geometry
  // ***************************************************************
  localparam logic [15:0] POLY16            = 16'h1021;
  localparam logic [31:0] POLY32            = 32'h04C11DB7;
  localparam logic [31:0] POLY32_REFL       = 32'hEDB88320;
  localparam logic [31:0] PRESET_ZEROS      = 32'h00000000;
  localparam logic [31:0] PRESET_ONES       = 32'hFFFFFFFF;
  localparam int          SECTOR_BYTES      = 512;
  localparam int          SECTOR_SHIFT      = 9;      // log2 of sector bytes
  localparam int          BITS_PER_BYTE     = 8;

  // ***************************************************************
  // state types
  // ***************************************************************
  typedef enum logic [1:0] {
    CCE_BUS_IDLE,
    CCE_BUS_WRITE,
    CCE_BUS_READ_WAIT,
    CCE_BUS_READ_DONE
  } cce_bus_state_t;

  typedef enum logic {
    CCE_AUTO_IDLE,
    CCE_AUTO_FETCH
  } cce_auto_state_t;

endpackage

/* cce_crc_unit.sv */
// byte-serial crc16 / reflected crc32 engine with ahb-lite registers and flash walk
`timescale 1ns/1ps

module cce_crc_unit #(
  parameter int FLASH_ADDR_W = 14,   // flash byte address width
  parameter int SECTOR_CNT_W = 8     // width of the sector count register
) (
  input  wire logic                    core_clk_in,      // system clock, 125 mhz
  input  wire logic                    reset_in,         // async reset, active high
  input  wire logic                    hsel_in,          // ahb slave select
  input  wire logic [31:0]             haddr_in,         // ahb address
  input  wire logic [1:0]              htrans_in,        // ahb transfer type
  input  wire logic                    hwrite_in,        // ahb write
  input  wire logic [2:0]              hsize_in,         // ahb size, word only
  input  wire logic [31:0]             hwdata_in,        // ahb write data
  input  wire logic                    hready_in,        // ahb bus ready
  output logic                         hreadyout_out,    // ahb slave ready
  output logic                         hresp_out,        // ahb response, always okay
  output logic [31:0]                  hrdata_out,       // ahb read data
  output logic                         flash_req_out,    // flash byte read request
  output logic [FLASH_ADDR_W-1:0]      flash_addr_out,   // flash byte address
  input  wire logic [7:0]              flash_rdata_in,   // flash byte data
  input  wire logic                    flash_rvalid_in,  // flash data valid pulse
  output logic                         cpu_stall_out     // hold cpu during auto run
);

  // countdown wide enough for the largest sector count times the sector size
  localparam int BYTE_CNT_W = SECTOR_CNT_W + cce_pkg::SECTOR_SHIFT;

  // ***************************************************************
  // helper functions
  // ***************************************************************

  // folds one byte into the result in the selected mode
  function automatic logic [31:0] crc_fold(input logic [31:0] acc,
                                           input logic [7:0]  din,
                                           input logic        w16);
    logic [31:0] a;
    integer      i;
    a = acc;
    // 16-bit folds keep the upper half at zero so a width change reads clean
    if (w16) begin
      a[31:16] = 16'h0000;
      a[15:8]  = a[15:8] ^ din;
      for (i = 0; i < cce_pkg::BITS_PER_BYTE; i = i + 1) begin
        if (a[15]) begin
          a[15:0] = {a[14:0], 1'b0} ^ cce_pkg::POLY16;
        end else begin
          a[15:0] = {a[14:0], 1'b0};
        end
      end
    end else begin
      // reflected form: the low bit decides, shifts run toward bit 0
      a[7:0] = a[7:0] ^ din;
      for (i = 0; i < cce_pkg::BITS_PER_BYTE; i = i + 1) begin
        if (a[0]) begin
          a = {1'b0, a[31:1]} ^ cce_pkg::POLY32_REFL;
        end else begin
          a = {1'b0, a[31:1]};
        end
      end
    end
    return a;
  endfunction

  // mirrors the bit order of a byte
  function automatic logic [7:0] bit_mirror(input logic [7:0] din);
    logic [7:0] r;
    integer     i;
    r = 8'h00;
    for (i = 0; i < 8; i = i + 1) begin
      r[i] = din[7-i];
    end
    return r;
  endfunction

  // maps the pointer to a result byte index
  function automatic logic [1:0] byte_index(input logic [1:0] ptr,
                                            input logic       w16);
    logic [1:0] idx;
    idx = ptr;
    // limitation: upper result bytes cannot be reached by pointer in 16-bit mode
    if (w16) begin
      idx = {1'b0, ptr[0]};
    end
    return idx;
  endfunction

  // ***************************************************************
  // state
  // ***************************************************************
  cce_pkg::cce_bus_state_t              bus_state;
  cce_pkg::cce_bus_state_t              next_bus_state;
  cce_pkg::cce_auto_state_t             auto_state;
  cce_pkg::cce_auto_state_t             next_auto_state;
  logic [7:0]                           bus_ofs;
  logic [7:0]                           next_bus_ofs;
  logic [31:0]                          rdata;
  logic [31:0]                          next_rdata;
  logic [31:0]                          result;
  logic [31:0]                          next_result;
  logic                                 width_sel;
  logic                                 next_width_sel;
  logic                                 preset_sel;
  logic                                 next_preset_sel;
  logic [1:0]                           ptr;
  logic [1:0]                           next_ptr;
  logic [7:0]                           last_input;
  logic [7:0]                           next_last_input;
  logic                                 auto_en;
  logic                                 next_auto_en;
  logic [cce_pkg::AUTO_PAGE_W-1:0]      start_page;
  logic [cce_pkg::AUTO_PAGE_W-1:0]      next_start_page;
  logic [SECTOR_CNT_W-1:0]              sector_count;
  logic [SECTOR_CNT_W-1:0]              next_sector_count;
  logic [7:0]                           mirror;
  logic [7:0]                           next_mirror;
  logic [FLASH_ADDR_W-1:0]              faddr;
  logic [FLASH_ADDR_W-1:0]              next_faddr;
  logic [BYTE_CNT_W-1:0]                bytes_left;
  logic [BYTE_CNT_W-1:0]                next_bytes_left;

  // decode and handshake helpers, all combinational; accept decodes the bus inputs, the rest come from flops
  logic                                 busy;
  logic                                 accept;
  logic                                 write_done;
  logic                                 read_capture;
  logic [1:0]                           sel_idx;
  logic [7:0]                           sel_byte;

  // ***************************************************************
  // bus handshake and decode helpers
  // ***************************************************************

  // busy stalls any data phase so the cpu cannot run on mid-walk
  assign busy          = (auto_state == cce_pkg::CCE_AUTO_FETCH);
  assign accept        = hsel_in && htrans_in[1] && hready_in;
  assign write_done    = (bus_state == cce_pkg::CCE_BUS_WRITE) && !busy;
  assign read_capture  = (bus_state == cce_pkg::CCE_BUS_READ_WAIT) && !busy;
  assign sel_idx       = byte_index(ptr, width_sel);
  assign sel_byte      = result[{sel_idx, 3'b000} +: 8];

  // reads always take at least one wait state so the pointer is settled first
  always_comb begin
    case (bus_state)
      cce_pkg::CCE_BUS_WRITE:     hreadyout_out = !busy;
      cce_pkg::CCE_BUS_READ_WAIT: hreadyout_out = 1'b0;
      default:                    hreadyout_out = 1'b1;
    endcase
  end

  // no error responses: every transfer completes, at worst after the walk
  assign hresp_out      = 1'b0;
  assign hrdata_out     = rdata;
  assign flash_req_out  = busy;
  assign flash_addr_out = faddr;
  assign cpu_stall_out  = busy;

  // ***************************************************************
  // next-state logic
  // ***************************************************************

  // one process for bus, registers and flash walk, so no byte is folded twice
  always_comb begin
    // every value holds unless a path below changes it
    next_bus_state    = bus_state;
    next_auto_state   = auto_state;
    next_bus_ofs      = bus_ofs;
    next_rdata        = rdata;
    next_result       = result;
    next_width_sel    = width_sel;
    next_preset_sel   = preset_sel;
    next_ptr          = ptr;
    next_last_input   = last_input;
    next_auto_en      = auto_en;
    next_start_page   = start_page;
    next_sector_count = sector_count;
    next_mirror       = mirror;
    next_faddr        = faddr;
    next_bytes_left   = bytes_left;

    // data phase of a write
    if (write_done) begin
      next_bus_state = cce_pkg::CCE_BUS_IDLE;
      case (bus_ofs)
        cce_pkg::CONTROL_OFS: begin
          next_width_sel  = hwdata_in[cce_pkg::CTL_WIDTH_BIT];
          next_preset_sel = hwdata_in[cce_pkg::CTL_PRESET_BIT];
          next_ptr        = hwdata_in[cce_pkg::CTL_PTR_LSB +: 2];
          if (hwdata_in[cce_pkg::CTL_INIT_BIT]) begin
            // preset taken from this same write; pointer untouched by init
            next_result = hwdata_in[cce_pkg::CTL_PRESET_BIT] ?
                          cce_pkg::PRESET_ONES : cce_pkg::PRESET_ZEROS;
          end
          // any control write launches the walk once armed
          if (auto_en && (sector_count != '0)) begin
            next_auto_state = cce_pkg::CCE_AUTO_FETCH;
            next_faddr      = FLASH_ADDR_W'({start_page, {cce_pkg::SECTOR_SHIFT{1'b0}}});
            next_bytes_left = BYTE_CNT_W'({sector_count, {cce_pkg::SECTOR_SHIFT{1'b0}}} - 1);
          end
        end
        cce_pkg::BYTE_INPUT_OFS: begin
          next_last_input = hwdata_in[7:0];
          next_result     = crc_fold(result, hwdata_in[7:0], width_sel);
        end
        cce_pkg::RESULT_PORT_OFS: begin
          next_result[{sel_idx, 3'b000} +: 8] = hwdata_in[7:0];
          next_ptr                            = ptr + 2'h1;
        end
        cce_pkg::AUTO_CONTROL_OFS: begin
          next_auto_en    = hwdata_in[cce_pkg::AUTO_EN_BIT];
          next_start_page = hwdata_in[cce_pkg::AUTO_PAGE_W-1:0];
        end
        cce_pkg::SECTOR_COUNT_OFS: begin
          next_sector_count = hwdata_in[SECTOR_CNT_W-1:0];
        end
        cce_pkg::BIT_REVERSE_OFS: begin
          next_mirror = bit_mirror(hwdata_in[7:0]);
        end
        default: begin
          next_bus_state = cce_pkg::CCE_BUS_IDLE;                     // unmapped write dropped
        end
      endcase
    end

    // read data captured into a flop, shown in the following cycle
    if (read_capture) begin
      next_bus_state = cce_pkg::CCE_BUS_READ_DONE;
      case (bus_ofs)
        cce_pkg::CONTROL_OFS: begin
          next_rdata = {27'h0, width_sel, 1'b0, preset_sel, ptr};
        end
        cce_pkg::BYTE_INPUT_OFS: begin
          next_rdata = {24'h0, last_input};
        end
        cce_pkg::RESULT_PORT_OFS: begin
          next_rdata = {24'h0, sel_byte};
          next_ptr   = ptr + 2'h1;
        end
        cce_pkg::AUTO_CONTROL_OFS: begin
          next_rdata = 32'({auto_en, 1'b0, start_page});
        end
        cce_pkg::SECTOR_COUNT_OFS: begin
          next_rdata = 32'(sector_count);
        end
        cce_pkg::BIT_REVERSE_OFS: begin
          next_rdata = {24'h0, mirror};
        end
        default: begin
          // unmapped offsets read as zero
          next_rdata = 32'h00000000;
        end
      endcase
    end

    // read data phase ends; idle follows unless a new address is taken
    if (bus_state == cce_pkg::CCE_BUS_READ_DONE) begin
      next_bus_state = cce_pkg::CCE_BUS_IDLE;
    end

    // new address phase, taken when selected with an active transfer and the bus ready
    // placed after the write and read paths so a back-to-back address phase wins over the idle return
    if (accept) begin
      next_bus_ofs   = haddr_in[7:0];
      next_bus_state = hwrite_in ? cce_pkg::CCE_BUS_WRITE : cce_pkg::CCE_BUS_READ_WAIT;
    end

    // flash walk: one byte per valid, address held until it arrives
    // trade-off: no prefetch, so a slow flash sets the pace of the whole walk
    if (busy && flash_rvalid_in) begin
      next_result = crc_fold(result, flash_rdata_in, width_sel);
      next_faddr  = faddr + FLASH_ADDR_W'(1);
      if (bytes_left == '0) begin
        next_auto_state = cce_pkg::CCE_AUTO_IDLE;
      end else begin
        next_bytes_left = bytes_left - BYTE_CNT_W'(1);
      end
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************

  // result holds its value unless one of the paths above changes it
  // every reset value is a constant; there is no synchronous clear path
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      bus_state    <= cce_pkg::CCE_BUS_IDLE;
      auto_state   <= cce_pkg::CCE_AUTO_IDLE;
      bus_ofs      <= 8'h00;
      rdata        <= 32'h00000000;
      result       <= cce_pkg::RESULT_RESET;
      width_sel    <= 1'b0;
      preset_sel   <= 1'b0;
      ptr          <= cce_pkg::PTR_RESET;
      last_input   <= cce_pkg::BYTE_RESET;
      auto_en      <= 1'b0;
      start_page   <= '0;
      sector_count <= '0;
      mirror       <= cce_pkg::BYTE_RESET;
      faddr        <= '0;
      bytes_left   <= '0;
    end else begin
      bus_state    <= next_bus_state;
      auto_state   <= next_auto_state;
      bus_ofs      <= next_bus_ofs;
      rdata        <= next_rdata;
      result       <= next_result;
      width_sel    <= next_width_sel;
      preset_sel   <= next_preset_sel;
      ptr          <= next_ptr;
      last_input   <= next_last_input;
      auto_en      <= next_auto_en;
      start_page   <= next_start_page;
      sector_count <= next_sector_count;
      mirror       <= next_mirror;
      faddr        <= next_faddr;
      bytes_left   <= next_bytes_left;
    end
  end

endmodule

/* cce_crc_unit_chk.sv */
// port assertions for the crc engine, bound into its top module
`timescale 1ns/1ps
module cce_crc_unit_chk #(
  parameter int FLASH_ADDR_W = 14  // flash byte address width
) (
  input wire logic                    core_clk_in,      // clock
  input wire logic                    reset_in,         // async reset
  input wire logic                    hsel_in,          // select
  input wire logic [31:0]             haddr_in,         // address
  input wire logic [1:0]              htrans_in,        // transfer type
  input wire logic                    hwrite_in,        // write
  input wire logic [2:0]              hsize_in,         // size
  input wire logic [31:0]             hwdata_in,        // write data
  input wire logic                    hready_in,        // bus ready
  input wire logic                    hreadyout_out,    // slave ready
  input wire logic                    hresp_out,        // response
  input wire logic [31:0]             hrdata_out,       // read data
  input wire logic                    flash_req_out,    // flash request
  input wire logic [FLASH_ADDR_W-1:0] flash_addr_out,   // flash address
  input wire logic [7:0]              flash_rdata_in,   // flash data
  input wire logic                    flash_rvalid_in,  // flash valid
  input wire logic                    cpu_stall_out     // cpu hold
);
  // ***************************************************************
  // helper: a data phase is outstanding
  // ***************************************************************
  logic taken;
  logic dphase;
  logic next_dphase;
  // a transfer taken opens a data phase, ready closes it
  always_comb begin
    taken = hsel_in & htrans_in[1] & hready_in;
    next_dphase = taken | (dphase & ~hreadyout_out);
  end
  // register only
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      dphase <= 1'b0;
    end else begin
      dphase <= next_dphase;
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  sequence rd_taken;
    taken && !hwrite_in && !flash_req_out;
  endsequence
  sequence wr_taken;
    taken && hwrite_in ##1 !flash_req_out;
  endsequence
  sequence fetch_wait;
    flash_req_out && !flash_rvalid_in ##1 flash_req_out;
  endsequence
  sequence fetch_step;
    flash_req_out && flash_rvalid_in ##1 flash_req_out;
  endsequence
  // ***************************************************************
  // assertions
  // ***************************************************************
  hresp_okay_a: assert property (hresp_out == 1'b0)
    else $error("response not okay");
  read_wait_a: assert property (rd_taken |=> !hreadyout_out)
    else $error("read answered without its wait cycle");
  write_ready_a: assert property (wr_taken |-> hreadyout_out)
    else $error("idle write held off");
  cpu_hold_a: assert property (dphase && flash_req_out |-> !hreadyout_out)
    else $error("transfer completed during walk");
  stall_match_a: assert property (cpu_stall_out == flash_req_out)
    else $error("stall differs from walk activity");
  page_align_a: assert property ($rose(flash_req_out) |-> flash_addr_out % 512 == 0)
    else $error("walk starts off a sector boundary");
  walk_min_a: assert property ($rose(flash_req_out) |-> flash_req_out [*8])
    else $error("walk ended too soon");
  addr_hold_a: assert property (fetch_wait |-> $stable(flash_addr_out))
    else $error("flash address moved without data");
  addr_step_a: assert property (fetch_step |-> flash_addr_out == $past(flash_addr_out) + 1'b1)
    else $error("flash address did not step by one");
  walk_end_a: assert property ($fell(flash_req_out) |-> $past(flash_rvalid_in) &&
    $past(flash_addr_out) % 512 == 511)
    else $error("walk ended inside a sector");
endmodule
bind cce_crc_unit cce_crc_unit_chk #(.FLASH_ADDR_W(FLASH_ADDR_W)) u_cce_crc_unit_chk (
  .core_clk_in, .reset_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hwdata_in,
  .hready_in, .hreadyout_out, .hresp_out, .hrdata_out, .flash_req_out, .flash_addr_out,
  .flash_rdata_in, .flash_rvalid_in, .cpu_stall_out);

/* cce_flash_model.sv */
// behavioural flash byte source answering the engine's walk
`timescale 1ns/1ps
module cce_flash_model #(
  parameter bit SLOW = 1'b1  // pulse only while tog is set; the pace stays one byte every two cycles either way
) (
  input  wire logic        clk_in,     // clock
  input  wire logic        reset_in,   // async reset
  input  wire logic        req_in,     // byte request level
  input  wire logic [13:0] addr_in,    // byte address
  output logic             rvalid_out, // data valid pulse
  output logic [7:0]       rdata_out   // byte data
);
  logic tog;
  // one pulse per byte; data inverted between pulses so stale bytes never match
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rvalid_out <= 1'b0;
      rdata_out  <= 8'h00;
      tog        <= 1'b0;
    end else begin
      tog <= ~tog;
      if (req_in && !rvalid_out && (tog || !SLOW)) begin
        rvalid_out <= 1'b1;
        rdata_out  <= addr_in[7:0] ^ {2'h0, addr_in[13:8]};
      end else begin
        rvalid_out <= 1'b0;
        rdata_out  <= ~rdata_out;
      end
    end
  end
endmodule

/* tb_cce_crc_unit.sv */
// self-checking bench for the crc engine over its ahb-lite registers
`timescale 1ns/1ps
module tb_cce_crc_unit;
  logic        core_clk_in;
  logic        reset_in;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [31:0] exp;
  logic        hreadyout;
  logic        hresp;
  logic        flash_req;
  logic        flash_rvalid;
  logic        stall;
  logic [13:0] flash_addr;
  logic [7:0]  flash_rdata;
  int          n_errors;
  int          comparisons;
  int          cyc;
  cce_crc_unit u_cce_crc_unit (.core_clk_in(core_clk_in), .reset_in(reset_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hreadyout), .hreadyout_out(hreadyout), .hresp_out(hresp), .hrdata_out(hrdata),
    .flash_req_out(flash_req), .flash_addr_out(flash_addr), .flash_rdata_in(flash_rdata),
    .flash_rvalid_in(flash_rvalid), .cpu_stall_out(stall));
  cce_flash_model u_cce_flash_model (.clk_in(core_clk_in), .reset_in(reset_in), .req_in(flash_req),
    .addr_in(flash_addr), .rvalid_out(flash_rvalid), .rdata_out(flash_rdata));
  // ***************************************************************
  // clock, timeout, helpers
  // ***************************************************************
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end
  // a hung handshake ends the run as a failure
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 10000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ready is judged at the falling edge, where the rising edge will see it
  task automatic wait_rdy();
    @(negedge core_clk_in);
    while (hreadyout !== 1'b1) @(negedge core_clk_in);
    rd = hrdata;
    @(posedge core_clk_in);
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    wait_rdy();
  endtask
  // reference fold, written from the algorithm text
  function automatic logic [31:0] crc_f(input logic [31:0] c, input logic [7:0] b, input logic w16);
    if (w16) begin
      c = {16'h0000, c[15:0] ^ {b, 8'h00}};
      for (int i = 0; i < 8; i++) c = {16'h0000, c[14:0], 1'b0} ^ (c[15] ? {16'h0000, cce_pkg::POLY16} : 32'h0);
    end else begin
      c = c ^ {24'h000000, b};
      for (int i = 0; i < 8; i++) c = (c >> 1) ^ (c[0] ? cce_pkg::POLY32_REFL : 32'h0);
    end
    return c;
  endfunction
  // pointer to 0, four byte reads, then the pointer must have wrapped
  task automatic rd_res(input logic [31:0] e, input logic w16);
    ahb(1'b1, cce_pkg::CONTROL_OFS, {27'h0, w16, 4'h0});
    for (int i = 0; i < 4; i++) begin
      ahb(1'b0, cce_pkg::RESULT_PORT_OFS, 32'h0);
      chk("result byte", {24'h0, e[8 * (w16 ? i % 2 : i) +: 8]}, rd);
    end
    ahb(1'b0, cce_pkg::CONTROL_OFS, 32'h0);
    chk("pointer wrap", {27'h0, w16, 4'h0}, rd);
  endtask
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    reset_in = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (10) @(posedge core_clk_in);
    reset_in <= 1'b0;
    @(posedge core_clk_in);
    ahb(1'b0, cce_pkg::CONTROL_OFS, 32'h0);
    chk("control reset", 32'h0, rd);
    rd_res(32'h0, 1'b0);
    ahb(1'b1, cce_pkg::CONTROL_OFS, 32'h0C);
    ahb(1'b1, cce_pkg::BYTE_INPUT_OFS, 32'h63);
    rd_res(32'hF9462090, 1'b0);
    ahb(1'b1, cce_pkg::CONTROL_OFS, 32'h1C);
    ahb(1'b0, cce_pkg::CONTROL_OFS, 32'h0);
    chk("control readback", 32'h14, rd);
    for (int i = 0; i < 3; i++) ahb(1'b1, cce_pkg::BYTE_INPUT_OFS, 32'hAA + 32'h11 * i);
    rd_res(32'h6CF6, 1'b1);
    ahb(1'b1, cce_pkg::CONTROL_OFS, 32'h08);
    rd_res(32'h0, 1'b0);
    ahb(1'b1, cce_pkg::CONTROL_OFS, 32'h01);
    ahb(1'b1, cce_pkg::RESULT_PORT_OFS, 32'hA5);
    rd_res(32'h0000A500, 1'b0);
    ahb(1'b1, cce_pkg::BYTE_INPUT_OFS, 32'h63);
    rd_res(crc_f(32'h0000A500, 8'h63, 1'b0), 1'b0);
    // every bit position through the mirror
    for (int i = 0; i < 8; i++) begin
      ahb(1'b1, cce_pkg::BIT_REVERSE_OFS, 32'h1 << i);
      ahb(1'b0, cce_pkg::BIT_REVERSE_OFS, 32'h0);
      chk("mirror", 32'h80 >> i, rd);
    end
    ahb(1'b1, 8'h20, 32'hFFFFFFFF);
    ahb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    // walk one sector from page 1 with preset ones
    exp = 32'hFFFFFFFF;
    for (int a = 512; a < 1024; a++) exp = crc_f(exp, a[7:0] ^ {2'h0, a[13:8]}, 1'b0);
    ahb(1'b1, cce_pkg::CONTROL_OFS, 32'h0C);
    ahb(1'b1, cce_pkg::AUTO_CONTROL_OFS, 32'h81);
    ahb(1'b1, cce_pkg::SECTOR_COUNT_OFS, 32'h01);
    ahb(1'b1, cce_pkg::CONTROL_OFS, 32'h04);
    @(negedge core_clk_in);
    chk("cpu stall", 32'h1, {31'h0, stall});
    @(posedge core_clk_in);
    ahb(1'b1, cce_pkg::AUTO_CONTROL_OFS, 32'h00);
    rd_res(exp, 1'b0);
    @(negedge core_clk_in);
    chk("no relaunch", 32'h0, {31'h0, stall});
    @(posedge core_clk_in);
    ahb(1'b0, cce_pkg::AUTO_CONTROL_OFS, 32'h0);
    chk("auto control", 32'h0, rd);
    ahb(1'b0, cce_pkg::SECTOR_COUNT_OFS, 32'h0);
    chk("sector count", 32'h1, rd);
    ahb(1'b0, cce_pkg::BYTE_INPUT_OFS, 32'h0);
    chk("last input", 32'h63, rd);
    finish_test();
  end
endmodule
